/* File: rtl/pcs_coding_pkg.sv */
// constants, code tables and coding functions for the 10/100 coding path
package pcs_coding_pkg;

  // ==========================================================================
  // clocking and rates
  localparam int MCLK_MHZ      = 100;
  localparam int LINE_RATE_MHZ = 125;
  localparam int ETH10_MBPS    = 10;
  localparam int BIT10_CYCLES  = MCLK_MHZ / ETH10_MBPS;
  localparam int MID_IGNORE    = (BIT10_CYCLES * 3) / 4;
  localparam int GAP10_CYCLES  = 2 * BIT10_CYCLES;
  localparam int HALF10_CYCLES = BIT10_CYCLES / 2;
  localparam int RX_LOCK_DEFAULT = 64;

  // ==========================================================================
  // symbol and scrambler layout
  localparam int SYM_BITS     = 5;
  localparam int NIBBLE_CODES = 16;
  localparam int LFSR_W       = 11;
  localparam int LFSR_TAP     = 8;
  localparam int LFSR_PERIOD  = 2047;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;

  localparam logic [4:0] SYM_IDLE = 5'h1f;
  localparam logic [4:0] SYM_J    = 5'h18;
  localparam logic [4:0] SYM_K    = 5'h11;
  localparam logic [4:0] SYM_T    = 5'h0d;
  localparam logic [4:0] SYM_R    = 5'h07;
  localparam logic [4:0] SYM_H    = 5'h04;

  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [3:0] SFD_HI  = 4'hd;

  // ==========================================================================
  // 4b/5b data code table
  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    case (nib)
      4'h0: enc4b5b = 5'h1e;
      4'h1: enc4b5b = 5'h09;
      4'h2: enc4b5b = 5'h14;
      4'h3: enc4b5b = 5'h15;
      4'h4: enc4b5b = 5'h0a;
      4'h5: enc4b5b = 5'h0b;
      4'h6: enc4b5b = 5'h0e;
      4'h7: enc4b5b = 5'h0f;
      4'h8: enc4b5b = 5'h12;
      4'h9: enc4b5b = 5'h13;
      4'ha: enc4b5b = 5'h16;
      4'hb: enc4b5b = 5'h17;
      4'hc: enc4b5b = 5'h1a;
      4'hd: enc4b5b = 5'h1b;
      4'he: enc4b5b = 5'h1c;
      default: enc4b5b = 5'h1d;
    endcase
  endfunction

  // returns {valid, nibble}
  function automatic logic [4:0] dec5b4b(input logic [4:0] sym);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NIBBLE_CODES; i++) begin
      if (enc4b5b(4'(i)) == sym) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

/* File: rtl/fast_ethernet_pcs_coding.sv */
// 10/100 line coding path: 4b/5b, scrambler, nrzi, mlt-3, manchester receive
//
// Overview of operation
// RULE1: serialize mii nibbles into 125 MHz bit stream; the code shifts one line bit per mclk cycle, and mclk is 100 MHz (MCLK_MHZ)
// RULE2: 4b/5b code first, then scramble the stream
// RULE3: scrambled bits go nrz to nrzi, then mlt-3
// RULE4: scrambler is an 11-bit lfsr, 100 mode only
// RULE5: 2047-bit sequence, receiver descrambles with same sequence
// RULE6: receive mlt-3 to nrz, descramble, decode, deparallelize
// RULE7: recover bit timing from incoming nrzi transitions; the code samples one bit per mclk and only sets rx_locked from them
// RULE8: 10 mode splits manchester into clock and data
// RULE9: 10 mode receive clock keeps running while idle
// RULE10: drop preamble, deliver frame starting at sfd; the code does so in 10 mode only, 100 mode delivers j/k as nibbles 5, 5
// RULE11: detect reversed 10 mode pair, invert polarity
// RULE12: standard 4b/5b table and scrambler polynomial
`timescale 1ns/10ps
`default_nettype none

module fast_ethernet_pcs_coding
  import pcs_coding_pkg::*;
#(
  parameter int RX_LOCK_BITS = RX_LOCK_DEFAULT
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // mode
  input  wire logic       speed_100,
  // mii transmit
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  input  wire logic [3:0] txd,
  output var  logic       tx_take,
  // 100 mode line
  output var  logic       tx_pos,
  output var  logic       tx_neg,
  input  wire logic       rx_pos,
  input  wire logic       rx_neg,
  // 10 mode line
  input  wire logic       rx10_line,
  // mii receive
  output var  logic [3:0] rxd,
  output var  logic       rx_dv,
  output var  logic       rx_er,
  output var  logic       rx_nib_vld,
  output var  logic       rx_clk10,
  output var  logic       rx_locked,
  output var  logic       pol_reversed
);

  if (RX_LOCK_BITS < 2 || RX_LOCK_BITS > 127) begin : g_bad_lock
    $error("RX_LOCK_BITS must lie in 2..127");
  end

  localparam logic [6:0] LOCK_LIMIT = 7'(RX_LOCK_BITS);
  localparam logic [2:0] SYM_LAST   = 3'(SYM_BITS - 1);
  localparam logic [3:0] LOAD_LAST  = 4'(LFSR_W - 1);
  localparam logic [4:0] MID_CYC    = 5'(MID_IGNORE);
  localparam logic [4:0] GAP_CYC    = 5'(GAP10_CYCLES);
  localparam logic [3:0] DIV_LAST   = 4'(BIT10_CYCLES - 1);
  localparam logic [3:0] DIV_HALF   = 4'(HALF10_CYCLES);

  // ==========================================================================
  // state
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;
  typedef enum logic {R1_HUNT, R1_FRAME} r1_state_t;
  typedef enum logic [1:0] {R10_IDLE, R10_PRE, R10_DATA} r10_state_t;

  typedef struct packed {
    tx_state_t   tx_state;
    logic [2:0]  tx_bitcnt;
    logic [4:0]  tx_sym;
    logic [10:0] tx_lfsr;
    logic        tx_nrzi;
    logic [1:0]  tx_phase;
    logic        tx_pos;
    logic        tx_neg;
    logic        tx_take;
    logic [1:0]  rx_mlt_prev;
    logic        rx_nrzi;
    logic        rx_nrzi_prev;
    logic [6:0]  rx_idle_cnt;
    logic        rx_locked;
    logic [10:0] rx_lfsr;
    logic [3:0]  rx_load_cnt;
    logic        rx_desc_lock;
    logic [9:0]  rx_sh;
    r1_state_t   r1_state;
    logic [2:0]  rx_symcnt;
    logic        line_prev;
    logic        pol_flip;
    logic [4:0]  r10_cnt;
    r10_state_t  r10_state;
    logic        r10_last;
    logic [1:0]  r10_nbits;
    logic [3:0]  r10_nib;
    logic        sfd_pend;
    logic [3:0]  r10_div;
    logic [3:0]  rxd;
    logic        rx_dv;
    logic        rx_er;
    logic        rx_nib_vld;
    logic        rx_clk10;
  } st_t;

  st_t s;
  st_t n;
  logic       nrz;
  logic       plain;
  logic [9:0] sh_next;
  logic       bit_ev;
  logic       corr;

  always_comb begin
    logic       key;
    logic       scr;
    logic [4:0] dec;
    logic       v1;
    logic [3:0] d1;
    logic       e1;
    logic       v10;
    logic [3:0] d10;
    key = 1'b0;
    scr = 1'b0;
    dec = 5'h00;
    v1  = 1'b0;
    d1  = 4'h0;
    e1  = 1'b0;
    v10 = 1'b0;
    d10 = 4'h0;
    n = s;
    n.tx_take = 1'b0;

    // ========================================================================
    // transmit: one line bit per clock, new symbol every five bits
    n.tx_bitcnt = (s.tx_bitcnt == SYM_LAST) ? 3'h0 : s.tx_bitcnt + 3'h1; // [RULE1]
    if (s.tx_bitcnt == SYM_LAST) begin
      case (s.tx_state)
        TX_IDLE: begin
          n.tx_sym = SYM_IDLE; // [RULE12]
          if (tx_en) begin
            n.tx_sym   = SYM_J; // [RULE2]
            n.tx_take  = 1'b1; // [RULE1]
            n.tx_state = TX_K;
          end
        end
        TX_K: begin
          n.tx_sym   = SYM_K;
          n.tx_take  = tx_en;
          n.tx_state = TX_DATA;
        end
        TX_DATA: begin
          if (tx_en) begin
            n.tx_sym  = tx_er ? SYM_H : enc4b5b(txd); // [RULE2] [RULE12]
            n.tx_take = 1'b1;
          end else begin
            n.tx_sym   = SYM_T;
            n.tx_state = TX_R;
          end
        end
        TX_R: begin
          n.tx_sym   = SYM_R;
          n.tx_state = TX_IDLE;
        end
        default: n.tx_state = TX_IDLE;
      endcase
    end else begin
      n.tx_sym = {s.tx_sym[3:0], 1'b0}; // [RULE1]
    end

    // scrambler x^11 + x^9 + 1, bypassed in 10 mode
    n.tx_lfsr = {s.tx_lfsr[9:0], s.tx_lfsr[LFSR_W-1] ^ s.tx_lfsr[LFSR_TAP]}; // [RULE4] [RULE12]
    scr = s.tx_sym[SYM_BITS-1] ^ (speed_100 & s.tx_lfsr[LFSR_W-1]); // [RULE2] [RULE5]
    n.tx_nrzi = s.tx_nrzi ^ scr; // [RULE3]
    if (n.tx_nrzi != s.tx_nrzi) begin
      n.tx_phase = s.tx_phase + 2'h1; // [RULE3]
    end
    n.tx_pos = speed_100 & (n.tx_phase == 2'h1);
    n.tx_neg = speed_100 & (n.tx_phase == 2'h3);

    // ========================================================================
    // 100 receive: mlt-3 -> nrzi -> nrz, timing lock from transitions
    n.rx_mlt_prev  = {rx_pos, rx_neg};
    if ({rx_pos, rx_neg} != s.rx_mlt_prev) begin
      n.rx_nrzi = ~s.rx_nrzi; // [RULE6]
    end
    n.rx_nrzi_prev = s.rx_nrzi;
    if (nrz) begin
      n.rx_idle_cnt = 7'h00; // [RULE7]
      n.rx_locked   = 1'b1;
    end else if (s.rx_idle_cnt == LOCK_LIMIT) begin
      n.rx_locked = 1'b0; // [RULE7]
    end else begin
      n.rx_idle_cnt = s.rx_idle_cnt + 7'h01;
    end

    // descrambler: load from idle (all ones) then free run
    key = s.rx_lfsr[LFSR_W-1] ^ s.rx_lfsr[LFSR_TAP];
    if (!s.rx_locked) begin
      n.rx_desc_lock = 1'b0;
      n.rx_load_cnt  = 4'h0;
    end else if (!s.rx_desc_lock) begin
      n.rx_lfsr     = {s.rx_lfsr[9:0], ~nrz}; // [RULE5]
      n.rx_load_cnt = s.rx_load_cnt + 4'h1;
      if (s.rx_load_cnt == LOAD_LAST) begin
        n.rx_desc_lock = 1'b1;
      end
    end else begin
      n.rx_lfsr = {s.rx_lfsr[9:0], key}; // [RULE5]
    end
    n.rx_sh = sh_next;

    // symbol alignment on idle/j, then decode every five bits
    if (!s.rx_desc_lock) begin
      n.r1_state = R1_HUNT;
    end else begin
      case (s.r1_state)
        R1_HUNT: begin
          if (sh_next == {SYM_IDLE, SYM_J}) begin
            n.r1_state  = R1_FRAME;
            n.rx_symcnt = 3'h0;
            v1 = 1'b1;
            d1 = PRE_NIB;
          end
        end
        R1_FRAME: begin
          n.rx_symcnt = (s.rx_symcnt == SYM_LAST) ? 3'h0 : s.rx_symcnt + 3'h1;
          if (s.rx_symcnt == SYM_LAST) begin
            dec = dec5b4b(sh_next[4:0]); // [RULE6] [RULE12]
            if (sh_next[4:0] == SYM_K) begin
              v1 = 1'b1;
              d1 = PRE_NIB;
            end else if (sh_next[4:0] == SYM_T || sh_next[4:0] == SYM_IDLE) begin
              n.r1_state = R1_HUNT; // [RULE6]
            end else begin
              v1 = 1'b1;
              d1 = dec[3:0];
              e1 = ~dec[4];
            end
          end
        end
        default: n.r1_state = R1_HUNT;
      endcase
    end

    // ========================================================================
    // 10 receive: manchester mid-bit edges give clock and data
    n.line_prev = rx10_line;
    if (bit_ev) begin
      n.r10_cnt = 5'h00; // [RULE8]
    end else if (s.r10_cnt != GAP_CYC) begin
      n.r10_cnt = s.r10_cnt + 5'h01;
    end
    if (bit_ev || s.r10_div == DIV_LAST) begin
      n.r10_div = 4'h0; // [RULE9]
    end else begin
      n.r10_div = s.r10_div + 4'h1; // [RULE9]
    end
    n.sfd_pend = 1'b0;
    if (s.sfd_pend) begin
      v10 = 1'b1;
      d10 = SFD_HI; // [RULE10]
    end
    if (s.r10_cnt == GAP_CYC) begin
      n.r10_state = R10_IDLE;
    end else begin
      case (s.r10_state)
        R10_IDLE: begin
          if (bit_ev) begin
            n.r10_state = R10_PRE;
            n.r10_last  = corr;
          end
        end
        R10_PRE: begin
          if (bit_ev) begin
            n.r10_last = corr;
            if (corr == s.r10_last) begin
              // two equal bits close the preamble; a 0-0 close means the pair is reversed
              n.pol_flip  = s.pol_flip ^ ~corr; // [RULE11]
              n.r10_state = R10_DATA; // [RULE10]
              n.r10_nbits = 2'h0;
              n.sfd_pend  = 1'b1;
              v10 = 1'b1;
              d10 = PRE_NIB; // [RULE10]
            end
          end
        end
        R10_DATA: begin
          if (bit_ev) begin
            n.r10_nib   = {corr, s.r10_nib[3:1]}; // [RULE8]
            n.r10_nbits = s.r10_nbits + 2'h1;
            if (s.r10_nbits == 2'h3) begin
              v10 = 1'b1;
              d10 = {corr, s.r10_nib[3:1]};
            end
          end
        end
        default: n.r10_state = R10_IDLE;
      endcase
    end

    // ========================================================================
    // mii receive outputs
    n.rx_clk10   = (n.r10_div < DIV_HALF); // [RULE9]
    n.rx_nib_vld = speed_100 ? v1 : v10;
    n.rx_er      = speed_100 & e1;
    if (n.rx_nib_vld) begin
      n.rxd = speed_100 ? d1 : d10; // [RULE6]
    end
    n.rx_dv = speed_100 ? (n.r1_state == R1_FRAME) : (n.r10_state == R10_DATA);
  end

  assign nrz     = s.rx_nrzi ^ s.rx_nrzi_prev; // [RULE7]
  assign plain   = s.rx_desc_lock ? (nrz ^ s.rx_lfsr[LFSR_W-1] ^ s.rx_lfsr[LFSR_TAP]) : 1'b1;
  assign sh_next = {s.rx_sh[8:0], plain}; // [RULE6]
  assign corr    = rx10_line ^ s.pol_flip; // [RULE11]
  assign bit_ev  = (rx10_line != s.line_prev) && (s.r10_cnt >= MID_CYC); // [RULE8]

  always_ff @(posedge mclk) begin
    if (reset) begin
      s         <= '0;
      s.tx_lfsr <= LFSR_SEED;
      s.tx_sym  <= SYM_IDLE;
    end else begin
      s <= n;
    end
  end

  assign tx_take      = s.tx_take;
  assign tx_pos       = s.tx_pos;
  assign tx_neg       = s.tx_neg;
  assign rxd          = s.rxd;
  assign rx_dv        = s.rx_dv;
  assign rx_er        = s.rx_er;
  assign rx_nib_vld   = s.rx_nib_vld;
  assign rx_clk10     = s.rx_clk10;
  assign rx_locked    = s.rx_locked;
  assign pol_reversed = s.pol_flip;

  // ==========================================================================
  // checks
  localparam int CHK_TOG = BIT10_CYCLES;
  logic [11:0] per_cnt;
  logic        per_seen;
  always_ff @(posedge mclk) begin
    if (reset) begin
      per_cnt  <= 12'h000;
      per_seen <= 1'b0;
    end else if (s.tx_lfsr == LFSR_SEED) begin
      per_cnt  <= 12'h001;
      per_seen <= 1'b1;
    end else begin
      per_cnt <= per_cnt + 12'h001;
    end
  end

  chk_take_spacing: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
    tx_take |=> !tx_take [*4]) else $error("nibbles taken closer than one symbol");
  chk_start_code: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
    (s.tx_state == TX_IDLE && s.tx_bitcnt == SYM_LAST && tx_en) |=> s.tx_sym == SYM_J)
    else $error("frame did not open with j");
  chk_mlt3_step: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
    (tx_pos |=> !tx_neg) and (tx_neg |=> !tx_pos)) else $error("mlt-3 skipped zero level");
  chk_lfsr_live: assert property (@(posedge mclk) disable iff (reset) // [RULE4]
    s.tx_lfsr != 11'h000) else $error("scrambler locked at zero");
  chk_lfsr_period: assert property (@(posedge mclk) disable iff (reset) // [RULE5]
    (s.tx_lfsr == LFSR_SEED && per_seen) |-> per_cnt == 12'(LFSR_PERIOD))
    else $error("scrambler period wrong");
  chk_end_code: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
    (speed_100 && s.r1_state == R1_FRAME && s.rx_symcnt == SYM_LAST && s.rx_desc_lock
     && sh_next[4:0] == SYM_T) |=> !rx_dv) else $error("t symbol did not end frame");
  chk_lock_loss: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
    (s.rx_idle_cnt == LOCK_LIMIT && !nrz) |=> !rx_locked) else $error("lock kept without edges");
  chk_man_bit: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
    (s.r10_state == R10_DATA && bit_ev && s.r10_cnt != GAP_CYC) |=> s.r10_nib[3] == $past(corr))
    else $error("manchester bit not captured");
  chk_clk10_runs: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
    rx_clk10 |-> ##[1:CHK_TOG] !rx_clk10) else $error("10 mode receive clock stalled");
  chk_sfd_first: assert property (@(posedge mclk) disable iff (reset) // [RULE10]
    (!speed_100 && s.r10_state == R10_PRE && n.r10_state == R10_DATA) |=>
    (rx_nib_vld && rxd == PRE_NIB) ##1 (rx_nib_vld && rxd == SFD_HI))
    else $error("frame did not start with sfd");
  chk_pol_flip: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
    (s.r10_state == R10_PRE && bit_ev && s.r10_cnt != GAP_CYC && corr == s.r10_last && !corr)
    |=> pol_reversed != $past(pol_reversed)) else $error("reversed pair not corrected");
  chk_idle_code: assert property (@(posedge mclk) disable iff (reset) // [RULE12]
    (s.tx_state == TX_IDLE && s.tx_bitcnt == SYM_LAST && !tx_en) |=> s.tx_sym == SYM_IDLE)
    else $error("idle code not sent");

  cov_tx_frame: cover property (@(posedge mclk) disable iff (reset)
    s.tx_state == TX_R);
  cov_rx100_frame: cover property (@(posedge mclk) disable iff (reset)
    speed_100 && rx_dv && rx_nib_vld);
  cov_rx10_sfd: cover property (@(posedge mclk) disable iff (reset)
    !speed_100 && rx_nib_vld && rxd == SFD_HI);
  cov_pol_flip: cover property (@(posedge mclk) disable iff (reset)
    $rose(pol_reversed));

endmodule

`default_nettype wire

/* File: test/mac_partner.sv */
// mac side model that feeds mii transmit nibbles on each consumption pulse
`timescale 1ns/10ps
`default_nettype none

module mac_partner (
  // clock
  input  wire logic       mclk,
  // mii transmit
  input  wire logic       tx_take,
  output var  logic       tx_en,
  output var  logic       tx_er,
  output var  logic [3:0] txd,
  // status
  output var  logic       stalled
);
  initial begin
    tx_en   = 1'b0;
    tx_er   = 1'b0;
    txd     = 4'h0;
    stalled = 1'b0;
  end

  // ==========================================================================
  // frame send: the next nibble goes out once the current one is consumed
  task automatic send(input logic [3:0] f[$], input int err_idx);
    int w;
    @(negedge mclk);
    tx_en = 1'b1;
    txd   = f[0];
    for (int i = 0; i < f.size(); i++) begin
      for (w = 0; w < 12; w++) begin
        @(negedge mclk);
        if (tx_take === 1'b1) break;
      end
      if (w == 12) stalled = 1'b1;
      if (i + 1 < f.size()) begin
        txd   = f[i + 1];
        tx_er = (i + 1 == err_idx);
      end else begin
        tx_en = 1'b0;
        tx_er = 1'b0;
      end
    end
  endtask
endmodule

`default_nettype wire

/* File: test/test_fast_ethernet_pcs_coding.sv */
// self-checking bench for the 10/100 line coding path
`timescale 1ns/10ps
`default_nettype none

module test_fast_ethernet_pcs_coding;
  import pcs_coding_pkg::*;
  localparam int LOCK_BITS = 32;
  logic        mclk, reset, speed_100, tx_en, tx_er, tx_take, tx_pos, tx_neg;
  logic        rx_pos, rx_neg, rx10_line, rx_dv, rx_er, rx_nib_vld, rx_clk10;
  logic        rx_locked, pol_reversed, stalled, key, b, pc;
  logic [3:0]  txd, rxd;
  logic [3:0]  rxq[$], txq[$], fr[$], ln[$];
  logic [7:0]  e;
  logic [10:0] dl;
  int          n_errors, cmp_count, lvl, plvl, lastnz, dcnt, st, sh, nb, ends, k, r, w, ed;
  int          code[16] = '{30, 9, 20, 21, 10, 11, 14, 15, 18, 19, 22, 23, 26, 27, 28, 29};
  int          erri, ti, ri;

  fast_ethernet_pcs_coding #(.RX_LOCK_BITS(LOCK_BITS)) dut (
    .mclk(mclk), .reset(reset), .speed_100(speed_100), .tx_en(tx_en), .tx_er(tx_er),
    .txd(txd), .tx_take(tx_take), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_pos(rx_pos),
    .rx_neg(rx_neg), .rx10_line(rx10_line), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .rx_nib_vld(rx_nib_vld), .rx_clk10(rx_clk10), .rx_locked(rx_locked),
    .pol_reversed(pol_reversed));

  mac_partner mac (
    .mclk(mclk), .tx_take(tx_take), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
    .stalled(stalled));

  always #5 mclk = ~mclk;

  // line loopback in 100 mode
  always @(negedge mclk) begin
    rx_pos = tx_pos;
    rx_neg = tx_neg;
  end

  // ==========================================================================
  // compare and verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic s100);
    @(negedge mclk);
    reset     = 1'b1;
    speed_100 = s100;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    repeat (5) @(negedge mclk);
  endtask

  task automatic man_bit(input logic bv, input logic inv);
    rx10_line = ~bv ^ inv;
    repeat (5) @(negedge mclk);
    rx10_line = bv ^ inv;
    repeat (5) @(negedge mclk);
  endtask

  task automatic drain(input int lim);
    for (w = 0; w < lim && (rxq.size() + txq.size()) > 0; w++) @(negedge mclk);
    if (w == lim) begin
      check("drain", 8'h01, 8'h00);
      print_verdict();
    end
  endtask

  // ==========================================================================
  // transmit line model: mlt-3 to nrz, self-locking descrambler, 5b decode
  always @(posedge mclk) begin
    if (reset || !speed_100) begin
      plvl   = 0;
      lastnz = -1;
      dcnt   = -8;
      st     = 0;
      sh     = 31;
    end else begin
      lvl = tx_pos ? 1 : (tx_neg ? -1 : 0);
      b   = (lvl != plvl);
      if (lvl != plvl) begin
        check("mlt3_step", 8'(lvl), 8'((plvl != 0) ? 0 : -lastnz));
        if (lvl != 0) lastnz = lvl;
      end
      plvl = lvl;
      if (dcnt < 11) begin
        if (dcnt >= 0) dl = {dl[9:0], ~b};
        dcnt++;
      end else begin
        key = dl[10] ^ dl[8];
        b   = b ^ key;
        dl  = {dl[9:0], key};
        sh  = ((sh << 1) | int'(b)) & 31;
        nb++;
        if (st == 0) begin
          if (!b && sh != 30 && sh != 28 && sh != 24) check("idle", 8'(sh), 8'd31);
          if (sh == 24) begin
            st = 1;
            nb = 0;
            if (txq.size() > 0) void'(txq.pop_front());
          end
        end else if (nb == 5) begin
          nb = 0;
          if (st == 1) begin
            check("tx_k", 8'(sh), 8'd17);
            if (txq.size() > 0) void'(txq.pop_front());
            st = 3;
            ti = 2;
          end else if (st == 2) begin
            check("tx_end", 8'(sh), 8'd7);
            st = 0;
            ends++;
          end else if (sh == 13) st = 2;
          else begin
            for (k = 0; k < 16 && code[k] != sh; k++);
            e = (txq.size() > 0) ? {4'h0, txq.pop_front()} : 8'h10;
            if (ti == erri) check("tx_err_code", 8'(sh), 8'd4);
            else check("tx_code", 8'(k), e);
            ti++;
          end
        end
      end
    end
  end

  // receive model: each strobe is matched to the next expected nibble
  always @(posedge mclk) begin
    if (!reset && rx_nib_vld === 1'b1) begin
      e = (rxq.size() > 0) ? {4'h0, rxq.pop_front()} : 8'h10;
      if (ri != erri) check("rxd", {4'h0, rxd}, e);
      check("rx_er", {7'h0, rx_er}, {7'h0, ri == erri});
      ri++;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    mclk      = 1'b0;
    reset     = 1'b1;
    speed_100 = 1'b1;
    rx10_line = 1'b0;
    rx_pos    = 1'b0;
    rx_neg    = 1'b0;
    n_errors  = 0;
    cmp_count = 0;
    ends      = 0;
    erri      = -1;
    ri        = 0;
    void'($urandom(59979));
    do_reset(1'b1);
    repeat (300) @(negedge mclk);
    check("rx_locked", {7'h0, rx_locked}, 8'h01);
    for (r = 0; r < 2; r++) begin
      fr = {4'h5, 4'h5};
      repeat (16) fr.push_back(4'($urandom));
      rxq = fr;
      txq = fr;
      erri = (r == 1) ? 10 : -1;
      ri   = 0;
      mac.send(fr, erri);
      drain(600);
      repeat (30) @(negedge mclk);
      check("rx_dv_end", {7'h0, rx_dv}, 8'h00);
    end
    check("tx_frames", 8'(ends), 8'd2);
    check("stalled", {7'h0, stalled}, 8'h00);
    erri      = -1;
    speed_100 = 1'b0;
    repeat (LOCK_BITS + 8) @(negedge mclk);
    check("rx_lock_loss", {7'h0, rx_locked}, 8'h00);
    $display("test 100 mode loopback done");
    do_reset(1'b0);
    ed = 0;
    pc = rx_clk10;
    repeat (100) begin
      @(posedge mclk);
      #1;
      if (rx_clk10 && !pc) ed++;
      pc = rx_clk10;
    end
    check("clk10_idle", 8'(ed), 8'd10);
    for (r = 0; r < 3; r++) begin
      fr = {4'h5, 4'hd};
      repeat (8) fr.push_back(4'($urandom));
      rxq = fr;
      ln  = fr;
      repeat (14) ln.push_front(4'h5);
      @(negedge mclk);
      rx10_line = (r > 0);
      repeat (30) @(negedge mclk);
      foreach (ln[i]) for (k = 0; k < 4; k++) man_bit(ln[i][k], r > 0);
      repeat (40) @(negedge mclk);
      check("rx10_left", 8'(rxq.size()), 8'h00);
      check("rx_dv10", {7'h0, rx_dv}, 8'h00);
      check("pol_rev", {7'h0, pol_reversed}, {7'h0, r > 0});
    end
    $display("test 10 mode receive done");
    print_verdict();
  end
endmodule

`default_nettype wire
